// File: gpio_pkg.sv
// Shared constants for the dual pin group and sleep indicator block
package gpio_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_GROUP_ACTIVATE = 8'h30;
  localparam logic [7:0] ADDR_ONE_DIRECTION = 8'he0;
  localparam logic [7:0] ADDR_ONE_PIN_DATA = 8'he1;
  localparam logic [7:0] ADDR_ONE_POLARITY = 8'he2;
  localparam logic [7:0] ADDR_ONE_EDGE_EVENTS = 8'he3;
  localparam logic [7:0] ADDR_TWO_DIRECTION = 8'he4;
  localparam logic [7:0] ADDR_TWO_PIN_DATA = 8'he5;
  localparam logic [7:0] ADDR_TWO_POLARITY = 8'he6;
  localparam logic [7:0] ADDR_TWO_EDGE_EVENTS = 8'he7;
  localparam logic [7:0] ADDR_SLEEP_INDICATOR_MODE = 8'hf3;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hf8;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'hf9;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hfa;
  // ----------------------------------------
  // Widths, fields and reset values
  // ----------------------------------------
  localparam int GROUP_ONE_WIDTH = 8;
  localparam int GROUP_TWO_WIDTH = 5;
  localparam int ACTIVATE_ONE_BIT = 0;
  localparam int ACTIVATE_TWO_BIT = 1;
  localparam int LED_MODE_LSB = 6;
  localparam int IRQ_ONE_BIT = 0;
  localparam int IRQ_TWO_BIT = 1;
  localparam logic [1:0] ACTIVATE_RESET = 2'h3;
  localparam logic [7:0] DIRECTION_RESET = 8'hff;
  localparam logic [7:0] PIN_DATA_RESET = 8'h00;
  localparam logic [7:0] POLARITY_RESET = 8'h00;
  localparam logic [7:0] EVENTS_RESET = 8'h00;
  localparam logic [1:0] LED_MODE_RESET = 2'h0;
  localparam logic [1:0] LED_MODE_LOW = 2'h0;
  localparam logic [1:0] LED_MODE_FLOAT = 2'h1;
  localparam logic [1:0] LED_MODE_FAST = 2'h2;
  localparam logic [1:0] LED_MODE_SLOW = 2'h3;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int LED_FAST_HALF_NS = 500_000_000;
  localparam int LED_SLOW_HALF_NS = 2_000_000_000;
  localparam int LED_FAST_HALF_CYCLES = LED_FAST_HALF_NS / CLOCK_PERIOD_NS;
  localparam int LED_SLOW_RATIO = LED_SLOW_HALF_NS / LED_FAST_HALF_NS;
  localparam logic [1:0] EDGE_WARMUP_CYCLES = 2'h3;
endpackage

// File: group_if.sv
// Configuration and sampled state passed between register file and one pin group
`timescale 1ns/10ps
interface group_if #(parameter int W = 8);
  logic active;
  logic [W-1:0] dir;
  logic [W-1:0] data;
  logic [W-1:0] polarity;
  logic [W-1:0] level;
  logic [W-1:0] event_hit;
  modport regs (output active, output dir, output data, output polarity,
    input level, input event_hit);
  modport pins (input active, input dir, input data, input polarity,
    output level, output event_hit);
endinterface

// File: pin_group.sv
// One pin group: input synchroniser, edge finder and registered pin drive
`timescale 1ns/10ps
module pin_group #(parameter int W = 8)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] pins_in,
  output logic [W-1:0] pins_out,
  output logic [W-1:0] pins_oe,
  group_if.pins g
);
  typedef struct packed {
    logic [W-1:0] sync_first;
    logic [W-1:0] sync_second;
    logic [W-1:0] prev;
    logic [W-1:0] hit;
    logic [W-1:0] drive;
    logic [W-1:0] enable;
    logic [1:0] warm;
  } pin_state_t;
  pin_state_t s;
  pin_state_t next_s;
  always_comb
  begin
    next_s = s;
    next_s.sync_first = pins_in;
    next_s.sync_second = s.sync_first;
    next_s.prev = s.sync_second;
    // Hold off edge capture until the synchroniser holds real pin levels
    if (s.warm != gpio_pkg::EDGE_WARMUP_CYCLES)
      next_s.warm = s.warm + 2'h1;
    next_s.hit = (s.warm == gpio_pkg::EDGE_WARMUP_CYCLES) ?
      ((s.sync_second ^ s.prev) & g.dir & {W{g.active}}) : '0;
    next_s.drive = g.data ^ g.polarity;
    next_s.enable = ~g.dir & {W{g.active}};
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end
  assign g.level = s.sync_second;
  assign g.event_hit = s.hit;
  assign pins_out = s.drive;
  assign pins_oe = s.enable;
endmodule

// File: led_blinker.sv
// Sleep indicator driver: low, floating or divided-down square wave
`timescale 1ns/10ps
module led_blinker #(parameter int HALF_CYCLES = gpio_pkg::LED_FAST_HALF_CYCLES)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] mode,
  output logic led_out,
  output logic led_oe
);
  localparam int CW = $clog2(HALF_CYCLES + 1);
  typedef struct packed {
    logic [CW-1:0] count;
    logic [1:0] sub;
    logic fast;
    logic slow;
    logic out;
    logic oe;
  } led_state_t;
  led_state_t s;
  led_state_t next_s;
  always_comb
  begin
    next_s = s;
    // Free-running reference so the wave phase does not depend on mode writes
    if (s.count == CW'(HALF_CYCLES - 1))
    begin
      next_s.count = '0;
      next_s.fast = ~s.fast;
      next_s.sub = s.sub + 2'h1;
      if (s.sub == 2'(gpio_pkg::LED_SLOW_RATIO - 1))
      begin
        next_s.sub = 2'h0;
        next_s.slow = ~s.slow;
      end
    end
    else
      next_s.count = s.count + CW'(1);
    unique case (mode)
      gpio_pkg::LED_MODE_LOW:
      begin
        next_s.out = 1'b0;
        next_s.oe = 1'b1;
      end
      gpio_pkg::LED_MODE_FLOAT:
      begin
        next_s.out = 1'b0;
        next_s.oe = 1'b0;
      end
      gpio_pkg::LED_MODE_FAST:
      begin
        next_s.out = next_s.fast;
        next_s.oe = 1'b1;
      end
      gpio_pkg::LED_MODE_SLOW:
      begin
        next_s.out = next_s.slow;
        next_s.oe = 1'b1;
      end
    endcase
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end
  assign led_out = s.out;
  assign led_oe = s.oe;
endmodule

// File: dual_gpio_group_with_sleep_led.sv
// Top: register file for two pin groups, edge events, interrupt and sleep LED
//
// Notes on behaviour
// - Each pin group has an activate bit, bit 1 for the second and bit 0 for the first, both set at reset.
// - Every pin has a direction bit where 0 is output and 1 is input, all reset to input.
// - Data bits of output pins are written and read back by software and drive the pins, reset zero.
// - Data bits of input pins read the pin state and ignore writes.
// - A polarity bit per pin, reset 0, makes data and pin level complements when set.
// - First group event bits 7 to 0 set on a rising or falling edge of the matching pin, only while it is an input and its group is active.
// - Second group uses event bits 4 to 0 only, one per pin in order.
// - Reading an event register returns the flags and clears those read; the registers reset to zero.
// - LED mode bits 7 to 6 choose low drive for 00 and floating for 01, reset 00, bits 5 to 0 reserved.
// - LED mode 10 gives a 1 Hz square wave with equal high and low times.
// - LED mode 11 gives a square wave of 4 s period at 50 percent duty.
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
module dual_gpio_group_with_sleep_led #(
  parameter int LED_HALF_CYCLES = gpio_pkg::LED_FAST_HALF_CYCLES
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [gpio_pkg::GROUP_ONE_WIDTH-1:0] first_group_pins_in,
  output logic [gpio_pkg::GROUP_ONE_WIDTH-1:0] first_group_pins_out,
  output logic [gpio_pkg::GROUP_ONE_WIDTH-1:0] first_group_pins_oe,
  input wire logic [gpio_pkg::GROUP_TWO_WIDTH-1:0] second_group_pins_in,
  output logic [gpio_pkg::GROUP_TWO_WIDTH-1:0] second_group_pins_out,
  output logic [gpio_pkg::GROUP_TWO_WIDTH-1:0] second_group_pins_oe,
  output logic sleep_indicator_led_out,
  output logic sleep_indicator_led_oe,
  output logic irq
);
  localparam int W1 = gpio_pkg::GROUP_ONE_WIDTH;
  localparam int W2 = gpio_pkg::GROUP_TWO_WIDTH;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] activate;
    logic [W1-1:0] one_dir;
    logic [W1-1:0] one_data;
    logic [W1-1:0] one_pol;
    logic [W1-1:0] one_events;
    logic [W2-1:0] two_dir;
    logic [W2-1:0] two_data;
    logic [W2-1:0] two_pol;
    logic [W2-1:0] two_events;
    logic [1:0] led_mode;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    logic [7:0] rdata;
    logic irq;
  } top_state_t;

  top_state_t s;
  top_state_t next_s;

  group_if #(.W(W1)) grp_one ();
  group_if #(.W(W2)) grp_two ();

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Only bits whose pin is an output take the written value
  function automatic logic [7:0] merge_write(input logic [7:0] dir, input logic [7:0] old,
                                             input logic [7:0] wval);
    merge_write = (old & dir) | (wval & ~dir);
  endfunction

  // Inputs read the pin through the polarity, outputs read back the stored bit
  function automatic logic [7:0] read_data(input logic [7:0] dir, input logic [7:0] stored,
                                           input logic [7:0] level, input logic [7:0] pol);
    read_data = (dir & (level ^ pol)) | (~dir & stored);
  endfunction

  // Flags set in the same cycle as a clearing read survive the clear
  function automatic logic [7:0] sticky(input logic [7:0] old, input logic [7:0] clr,
                                        input logic [7:0] hit);
    sticky = (old & ~clr) | hit;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [7:0] one_clear;
    logic [7:0] two_clear;
    logic [1:0] irq_hits;
    logic [1:0] irq_wclear;
    one_clear = 8'h00;
    two_clear = 8'h00;
    irq_hits = 2'h0;
    irq_wclear = 2'h0;
    next_s = s;
    next_s.rdata = 8'h00;

    if (wr)
    begin
      unique case (addr)
        gpio_pkg::ADDR_GROUP_ACTIVATE:
          next_s.activate = wdata[1:0];
        gpio_pkg::ADDR_ONE_DIRECTION:
          next_s.one_dir = wdata;
        gpio_pkg::ADDR_ONE_PIN_DATA:
          next_s.one_data = merge_write(s.one_dir, s.one_data, wdata);
        gpio_pkg::ADDR_ONE_POLARITY:
          next_s.one_pol = wdata;
        gpio_pkg::ADDR_TWO_DIRECTION:
          next_s.two_dir = wdata[W2-1:0];
        gpio_pkg::ADDR_TWO_PIN_DATA:
        begin
          next_s.two_data = W2'(merge_write({3'h0, s.two_dir}, {3'h0, s.two_data},
                                            wdata));
        end
        gpio_pkg::ADDR_TWO_POLARITY:
          next_s.two_pol = wdata[W2-1:0];
        gpio_pkg::ADDR_SLEEP_INDICATOR_MODE:
          next_s.led_mode = wdata[gpio_pkg::LED_MODE_LSB +: 2];
        gpio_pkg::ADDR_IRQ_CLEAR:
          irq_wclear = wdata[1:0];
        gpio_pkg::ADDR_IRQ_ENABLE:
          next_s.irq_enable = wdata[1:0];
        default:
          next_s.activate = s.activate;
      endcase
    end

    if (rd)
    begin
      unique case (addr)
        gpio_pkg::ADDR_GROUP_ACTIVATE:
          next_s.rdata = {6'h00, s.activate};
        gpio_pkg::ADDR_ONE_DIRECTION:
          next_s.rdata = s.one_dir;
        gpio_pkg::ADDR_ONE_PIN_DATA:
          next_s.rdata = read_data(s.one_dir, s.one_data, grp_one.level, s.one_pol);
        gpio_pkg::ADDR_ONE_POLARITY:
          next_s.rdata = s.one_pol;
        gpio_pkg::ADDR_ONE_EDGE_EVENTS:
        begin
          next_s.rdata = s.one_events;
          one_clear = s.one_events;
        end
        gpio_pkg::ADDR_TWO_DIRECTION:
          next_s.rdata = {3'h0, s.two_dir};
        gpio_pkg::ADDR_TWO_PIN_DATA:
        begin
          next_s.rdata = read_data({3'h0, s.two_dir}, {3'h0, s.two_data},
                                   {3'h0, grp_two.level}, {3'h0, s.two_pol});
        end
        gpio_pkg::ADDR_TWO_POLARITY:
          next_s.rdata = {3'h0, s.two_pol};
        gpio_pkg::ADDR_TWO_EDGE_EVENTS:
        begin
          next_s.rdata = {3'h0, s.two_events};
          two_clear = {3'h0, s.two_events};
        end
        gpio_pkg::ADDR_SLEEP_INDICATOR_MODE:
          next_s.rdata = {s.led_mode, 6'h00};
        gpio_pkg::ADDR_IRQ_STATUS:
          next_s.rdata = {6'h00, s.irq_status};
        gpio_pkg::ADDR_IRQ_ENABLE:
          next_s.rdata = {6'h00, s.irq_enable};
        default:
          next_s.rdata = 8'h00;
      endcase
    end

    // ----------------------------------------
    // Edge events and interrupt
    // ----------------------------------------
    next_s.one_events = sticky(s.one_events, one_clear, grp_one.event_hit);
    next_s.two_events = W2'(sticky({3'h0, s.two_events}, two_clear,
                                   {3'h0, grp_two.event_hit}));
    irq_hits[gpio_pkg::IRQ_ONE_BIT] = |grp_one.event_hit;
    irq_hits[gpio_pkg::IRQ_TWO_BIT] = |grp_two.event_hit;
    next_s.irq_status = (s.irq_status & ~irq_wclear) | irq_hits;
    next_s.irq = |(next_s.irq_status & next_s.irq_enable);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.activate <= gpio_pkg::ACTIVATE_RESET;
      s.one_dir <= gpio_pkg::DIRECTION_RESET;
      s.two_dir <= gpio_pkg::DIRECTION_RESET[W2-1:0];
      s.one_data <= gpio_pkg::PIN_DATA_RESET;
      s.two_data <= gpio_pkg::PIN_DATA_RESET[W2-1:0];
      s.one_pol <= gpio_pkg::POLARITY_RESET;
      s.two_pol <= gpio_pkg::POLARITY_RESET[W2-1:0];
      s.one_events <= gpio_pkg::EVENTS_RESET;
      s.two_events <= gpio_pkg::EVENTS_RESET[W2-1:0];
      s.led_mode <= gpio_pkg::LED_MODE_RESET;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------
  // Group wiring
  // ----------------------------------------
  assign grp_one.active = s.activate[gpio_pkg::ACTIVATE_ONE_BIT];
  assign grp_one.dir = s.one_dir;
  assign grp_one.data = s.one_data;
  assign grp_one.polarity = s.one_pol;
  assign grp_two.active = s.activate[gpio_pkg::ACTIVATE_TWO_BIT];
  assign grp_two.dir = s.two_dir;
  assign grp_two.data = s.two_data;
  assign grp_two.polarity = s.two_pol;

  pin_group #(.W(W1)) u_group_one (
    .clock(clock),
    .rst(rst),
    .pins_in(first_group_pins_in),
    .pins_out(first_group_pins_out),
    .pins_oe(first_group_pins_oe),
    .g(grp_one)
  );

  pin_group #(.W(W2)) u_group_two (
    .clock(clock),
    .rst(rst),
    .pins_in(second_group_pins_in),
    .pins_out(second_group_pins_out),
    .pins_oe(second_group_pins_oe),
    .g(grp_two)
  );

  led_blinker #(.HALF_CYCLES(LED_HALF_CYCLES)) u_led (
    .clock(clock),
    .rst(rst),
    .mode(s.led_mode),
    .led_out(sleep_indicator_led_out),
    .led_oe(sleep_indicator_led_oe)
  );

  assign rdata = s.rdata;
  assign irq = s.irq;
endmodule

// File: board_model.sv
// Board side: pin loop-back, external levels and the pulled-up indicator LED
`timescale 1ns/10ps
module board_model
(
  input wire logic [7:0] first_out,
  input wire logic [7:0] first_oe,
  input wire logic [7:0] first_ext,
  output logic [7:0] first_in,
  input wire logic [4:0] second_out,
  input wire logic [4:0] second_oe,
  input wire logic [4:0] second_ext,
  output logic [4:0] second_in,
  input wire logic led_out,
  input wire logic led_oe,
  output logic led_level
);
  // A driven pin reads back its own level, a released one the board level
  assign first_in = (first_oe & first_out) | (~first_oe & first_ext);
  assign second_in = (second_oe & second_out) | (~second_oe & second_ext);
  // Pull-up to the LED supply shows a floating pin as high
  assign led_level = led_oe ? led_out : 1'b1;
endmodule

// File: gpio_checker.sv
// Port checker for the dual pin group block
`timescale 1ns/10ps
module gpio_checker #(parameter int LED_HALF_CYCLES = 10)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [7:0] first_group_pins_oe,
  input wire logic [4:0] second_group_pins_oe,
  input wire logic sleep_indicator_led_out,
  input wire logic sleep_indicator_led_oe,
  input wire logic irq
);
  // ----------------------------------------
  // Mirror of the configuration seen on the bus
  // ----------------------------------------
  localparam int SETTLE = 8 * LED_HALF_CYCLES + 4;
  logic [1:0] act;
  logic [7:0] dir1;
  logic [4:0] dir2;
  logic [1:0] mode;
  logic [1:0] en;
  logic last_led;
  int run;
  int age;
  logic mode_wr;
  logic led_edge;
  assign mode_wr = wr && addr == gpio_pkg::ADDR_SLEEP_INDICATOR_MODE;
  assign led_edge = age > SETTLE && sleep_indicator_led_out != last_led;
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      act <= 2'h3;
      dir1 <= 8'hff;
      dir2 <= 5'h1f;
      mode <= 2'h0;
      en <= 2'h0;
      last_led <= 1'b0;
      run <= 0;
      age <= 0;
    end
    else
    begin
      if (wr && addr == gpio_pkg::ADDR_GROUP_ACTIVATE)
        act <= wdata[1:0];
      if (wr && addr == gpio_pkg::ADDR_ONE_DIRECTION)
        dir1 <= wdata;
      if (wr && addr == gpio_pkg::ADDR_TWO_DIRECTION)
        dir2 <= wdata[4:0];
      if (wr && addr == gpio_pkg::ADDR_IRQ_ENABLE)
        en <= wdata[1:0];
      if (wr && addr == gpio_pkg::ADDR_SLEEP_INDICATOR_MODE)
        mode <= wdata[7:6];
      // Blink spans are only judged once a whole slow period has passed
      age <= mode_wr ? 0 : (age > SETTLE ? age : age + 1);
      last_led <= sleep_indicator_led_out;
      run <= (sleep_indicator_led_out != last_led) ? 0 : run + 1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not idle");
  AST_LED_LOW: assert property (mode_wr && wdata[7:6] == 2'h0 |-> ##2
    (sleep_indicator_led_oe && !sleep_indicator_led_out))
    else $error("indicator not driven low");
  AST_LED_FLOAT: assert property (mode_wr && wdata[7:6] == 2'h1 |-> ##2
    !sleep_indicator_led_oe)
    else $error("indicator not floating");
  AST_LED_FAST: assert property (mode == 2'h2 && led_edge |-> run == LED_HALF_CYCLES - 1)
    else $error("fast blink half period wrong");
  AST_LED_SLOW: assert property (mode == 2'h3 && led_edge |->
    run == 4 * LED_HALF_CYCLES - 1)
    else $error("slow blink half period wrong");
  AST_IRQ_MASK: assert property (en == 2'h0 && $past(en) == 2'h0 |-> !irq)
    else $error("interrupt while disabled");
  AST_OE_ONE: assert property (first_group_pins_oe == $past(~dir1 & {8{act[0]}}))
    else $error("first group enables wrong");
  AST_OE_TWO: assert property (second_group_pins_oe == $past(~dir2 & {5{act[1]}}))
    else $error("second group enables wrong");
  cover property (mode == 2'h2 && led_edge);
  cover property (mode == 2'h3 && led_edge);
  cover property ($rose(irq));
endmodule

// File: dual_gpio_group_with_sleep_led_tb_top.sv
// Self-checking bench for the dual pin group block
`timescale 1ns/10ps
module dual_gpio_group_with_sleep_led_tb_top;
  localparam int HALF = 10;
  typedef struct packed {logic [7:0] a; logic [7:0] e;} row_t;
  logic clock = 1'b0;
  logic rst;
  logic [7:0] addr, wdata, rdata, p1_in, p1_out, p1_oe, ext1, d;
  logic wr, rd, led_out, led_oe, led_level, irq;
  logic [4:0] p2_in, p2_out, p2_oe, ext2;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  row_t rows[13] = '{'{8'h30, 8'h03}, '{8'he0, 8'hff}, '{8'he1, 8'h00}, '{8'he2, 8'h00},
    '{8'he3, 8'h00}, '{8'he4, 8'h1f}, '{8'he5, 8'h00}, '{8'he6, 8'h00}, '{8'he7, 8'h00},
    '{8'hf3, 8'h00}, '{8'hf8, 8'h00}, '{8'hfa, 8'h00}, '{8'h55, 8'h00}};
  always #50 clock = ~clock;
  dual_gpio_group_with_sleep_led #(.LED_HALF_CYCLES(HALF)) i_dual_gpio_group_with_sleep_led (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .first_group_pins_in(p1_in), .first_group_pins_out(p1_out), .first_group_pins_oe(p1_oe),
    .second_group_pins_in(p2_in), .second_group_pins_out(p2_out), .second_group_pins_oe(p2_oe),
    .sleep_indicator_led_out(led_out), .sleep_indicator_led_oe(led_oe), .irq(irq));
  board_model i_board_model (.first_out(p1_out), .first_oe(p1_oe), .first_ext(ext1),
    .first_in(p1_in), .second_out(p2_out), .second_oe(p2_oe), .second_ext(ext2),
    .second_in(p2_in), .led_out(led_out), .led_oe(led_oe), .led_level(led_level));
  // ----------------------------------------
  // Bus, compare and closing tasks
  // ----------------------------------------
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    v = rdata;
  endtask
  task automatic irq_is(input string name, input logic v);
    repeat (2) @(negedge clock);
    check(name, {7'h0, irq}, {7'h0, v});
  endtask
  // Length of the third steady stretch of the indicator, bounded when it never moves
  task automatic span(output int len);
    logic v;
    for (int k = 0; k < 3; k++)
    begin
      len = 0;
      v = led_out;
      while (led_out === v && len < 200)
      begin
        @(negedge clock);
        len++;
      end
    end
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      err_total++;
      results();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    ext1 = 8'h00;
    ext2 = 5'h00;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    wr_reg(8'h55, 8'hff);
    wr_reg(8'he3, 8'hff);
    foreach (rows[i])
    begin
      rd_reg(rows[i].a, d);
      check("reset_value", d, rows[i].e);
    end
    ext1 <= 8'hc0;
    wr_reg(8'he0, 8'hf0);
    wr_reg(8'he2, 8'h03);
    wr_reg(8'he1, 8'ha5);
    rd_reg(8'he1, d);
    check("data_mixed", d, 8'hc5);
    check("pin_drive", p1_out & p1_oe, 8'h06);
    check("pin_enable", p1_oe, 8'h0f);
    wr_reg(8'he2, 8'h33);
    rd_reg(8'he1, d);
    check("data_invert", d, 8'hf5);
    rd_reg(8'he3, d);
    rd_reg(8'he7, d);
    wr_reg(8'hf9, 8'h03);
    ext1 <= 8'h40;
    ext2 <= 5'h11;
    repeat (6) @(posedge clock);
    rd_reg(8'hf8, d);
    check("irq_status", d, 8'h03);
    irq_is("irq_masked", 1'b0);
    rd_reg(8'he3, d);
    check("events_one", d, 8'h80);
    rd_reg(8'he3, d);
    check("events_one_cleared", d, 8'h00);
    rd_reg(8'he7, d);
    check("events_two", d, 8'h11);
    wr_reg(8'hfa, 8'h03);
    irq_is("irq_on", 1'b1);
    wr_reg(8'hfa, 8'h00);
    irq_is("irq_disabled", 1'b0);
    wr_reg(8'hfa, 8'h03);
    wr_reg(8'hf9, 8'h01);
    irq_is("irq_one_left", 1'b1);
    wr_reg(8'hf9, 8'h02);
    irq_is("irq_cleared", 1'b0);
    wr_reg(8'h30, 8'h02);
    repeat (2) @(negedge clock);
    check("group_off", p1_oe, 8'h00);
    wr_reg(8'h30, 8'h03);
    wr_reg(8'he4, 8'h00);
    wr_reg(8'he6, 8'h03);
    wr_reg(8'he5, 8'h0a);
    rd_reg(8'he5, d);
    check("two_data", d, 8'h0a);
    check("two_drive", {3'h0, p2_out & p2_oe}, 8'h09);
    check("two_enable", {3'h0, p2_oe}, 8'h1f);
    for (int m = 0; m < 4; m++)
    begin
      wr_reg(8'hf3, {m[1:0], 6'h3f});
      rd_reg(8'hf3, d);
      check("led_mode", d, {m[1:0], 6'h00});
      span(n);
      if (m < 2)
        check("led_level", {7'h0, led_level}, {7'h0, m[0]});
      else
        check("led_half", 8'(n), (m == 2) ? 8'(HALF) : 8'(4 * HALF));
      repeat (120) @(negedge clock);
    end
    // Reset again while group two pins 4 and 0 sit high, to prove no false edges follow
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check("reset_two_enable", {3'h0, p2_oe}, 8'h00);
    rd_reg(8'hf3, d);
    check("reset_mode", d, 8'h00);
    rd_reg(8'he4, d);
    check("reset_two_dir", d, 8'h1f);
    rd_reg(8'he7, d);
    check("reset_no_event", d, 8'h00);
    results();
  end
endmodule

bind dual_gpio_group_with_sleep_led gpio_checker #(.LED_HALF_CYCLES(LED_HALF_CYCLES))
  i_gpio_checker (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .first_group_pins_oe(first_group_pins_oe),
  .second_group_pins_oe(second_group_pins_oe),
  .sleep_indicator_led_out(sleep_indicator_led_out),
  .sleep_indicator_led_oe(sleep_indicator_led_oe), .irq(irq));
